// *** pio_pkg.sv ***
// shared constants for the programmed i/o card and its cpu-side controller
// assumes a single 50 MHz clock for both ends
package pio_pkg;
   localparam int DW = 16;
   localparam int AW = 11;
   localparam int CLK_MHZ = 50;
   // no-connect limit of the execute cycle, longest time rounds down
   localparam int TIMEOUT_NS = 5000;
   localparam int TIMEOUT_CYC = TIMEOUT_NS * CLK_MHZ / 1000;
   localparam logic [7:0] TIMEOUT_CNT = 8'(TIMEOUT_CYC);
   // card address fields
   localparam int ADR_DIR = 0;
   localparam int ADR_SPACE = 10;
   localparam logic [6:0] CARD_ADDR_RST = 7'h10;
   // register index inside the card, bit 0 is the direction bit
   localparam logic [2:0] RI_IN_DATA = 3'h0;
   localparam logic [2:0] RI_OUT_DATA = 3'h1;
   localparam logic [2:0] RI_IN_STAT = 3'h2;
   localparam logic [2:0] RI_IN_CTL = 3'h3;
   localparam logic [2:0] RI_TEST_RD = 3'h4;
   localparam logic [2:0] RI_TEST_WR = 3'h5;
   localparam logic [2:0] RI_OUT_STAT = 3'h6;
   localparam logic [2:0] RI_OUT_CTL = 3'h7;
   // control word fields
   localparam int CW_RDY_IE = 0;
   localparam int CW_ERR_IE = 1;
   localparam int CW_ACT = 2;
   localparam int CW_TEST = 3;
   localparam int CW_CLR = 4;
   // status word fields
   localparam int SW_RDY_IE = 0;
   localparam int SW_ERR_IE = 1;
   localparam int SW_ACT = 2;
   localparam int SW_RDY = 3;
   localparam int SW_ERR_ANY = 4;
   localparam int SW_ERR_LO = 5;
   localparam int SW_UNIT_LO = 9;
   localparam int SW_MODE_LO = 11;
   localparam logic [DW-1:0] WORD_RST = 16'h0000;
   // controller wishbone map (byte addresses)
   localparam logic [7:0] WB_CMD = 8'h00;
   localparam logic [7:0] WB_ACC = 8'h04;
   localparam logic [7:0] WB_STAT = 8'h08;
   localparam int CMD_MCLR = 16;
   typedef enum logic [1:0] {D_IDLE, D_ACT, D_DRV, D_CONN} pio_dev_state_t;
   typedef enum logic [1:0] {H_IDLE, H_WAIT, H_EXEC, H_DROP} pio_cpu_state_t;

   // builds the status word of one direction from its control copy and state
   function automatic logic [DW-1:0] pio_status(input logic [DW-1:0] ctl, input logic act,
                                                 input logic rdy, input logic [3:0] err);
      logic [DW-1:0] s;
      s = WORD_RST;
      s[SW_RDY_IE] = ctl[CW_RDY_IE];
      s[SW_ERR_IE] = ctl[CW_ERR_IE];
      s[SW_ACT] = act;
      s[SW_RDY] = rdy;
      s[SW_ERR_ANY] = |err;
      s[SW_ERR_LO +: 4] = err;
      s[SW_UNIT_LO +: 2] = ctl[SW_UNIT_LO +: 2];
      s[SW_MODE_LO +: 5] = ctl[SW_MODE_LO +: 5];
      return s;
   endfunction
endpackage

// *** pio_bus_if.sv ***
// local i/o bus between the cpu-side controller and one card
// assumes both ends share clk; the data wire is resolved from the two enables
`timescale 1ns/1ps
interface pio_bus_if;
   import pio_pkg::*;
   logic [AW-1:0] addr;
   logic [DW-1:0] cpu_data;
   logic cpu_oe;
   logic [DW-1:0] dev_data;
   logic dev_oe;
   logic [DW-1:0] io_data_lines;
   logic local_execute_enable;
   logic bus_connect_ack;
   logic bus_input_direction;
   logic bus_master_clear;
   logic ready_irq_in;
   logic ready_irq_out;

   // three-state wire: the driving side wins, idle bus reads zero
   assign io_data_lines = dev_oe ? dev_data : (cpu_oe ? cpu_data : WORD_RST);

   modport device (input addr, input io_data_lines, input local_execute_enable, input bus_master_clear,
                   output dev_data, output dev_oe, output bus_connect_ack, output bus_input_direction,
                   output ready_irq_in, output ready_irq_out);
   modport cpu (output addr, output cpu_data, output cpu_oe, output local_execute_enable,
                output bus_master_clear, input io_data_lines, input bus_connect_ack,
                input bus_input_direction, input ready_irq_in, input ready_irq_out);
endinterface

// *** pio_card.sv ***
// two-way programmed i/o card: input and output data, control and status words
// assumes the cpu end holds address and data stable while the execute enable is high
`timescale 1ns/1ps
// Function
// - input loads accumulator, output leaves it
// - execute cycle lasts about one to five microseconds; the code ends it at connect, cut off after 250 cycles (5 us) at 50 MHz
// - execute cycle waits for dma to finish
// - host writes control word before input
// - input ready bit set when word arrives
// - ready with enable raises interrupt line
// - output ready bit means buffer is free
// - control write with activate sends buffered word
// - status word bit layout
// - control word bit layout
// - sixteen data lines, direction picks the driver
// - address lines carry register and space bit
// - enable routed local or external by strap
// - connect only after decode and data ready
// - connect within five microseconds or error
// - input direction true for device to cpu
// - master clear resets all card logic
// - compare strapped address, decode low bits
// - address bit zero selects output or input
// - hold connect and input until enable drops
module pio_card #(
   parameter logic [6:0] CARD_ADDR = pio_pkg::CARD_ADDR_RST
) (
   input wire logic clk,
   input wire logic reset_n,
   pio_bus_if.device bus,
   input wire logic [pio_pkg::DW-1:0] rx_data,
   input wire logic rx_strobe,
   input wire logic rx_error,
   output logic [pio_pkg::DW-1:0] tx_data,
   output logic tx_strobe,
   input wire logic tx_done,
   input wire logic tx_error,
   output logic test_mode
);
   import pio_pkg::*;

   pio_dev_state_t state_q;
   logic [DW-1:0] ibuf_q, obuf_q, dout_q, ictl_q, octl_q;
   logic iact_q, oact_q, irdy_q, ordy_q, input_q, oe_q, conn_q, irq_i_q, irq_o_q;
   logic [3:0] ierr_q, oerr_q;
   logic [DW-1:0] tx_data_q;
   logic tx_strobe_q, test_q;
   logic hit, wr_go, rd_go, mclr;
   logic [2:0] ri;

   assign mclr = bus.bus_master_clear;
   assign ri = bus.addr[2:0];
   // card responds to its eight slots only, space bit is the branch's business
   assign hit = bus.addr[9:3] == CARD_ADDR;
   assign wr_go = (state_q == D_IDLE) && bus.local_execute_enable && hit && bus.addr[ADR_DIR];
   assign rd_go = (state_q == D_IDLE) && bus.local_execute_enable && hit && !bus.addr[ADR_DIR];

   // handshake sequencer: act, then drive, then connect until enable falls
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= D_IDLE;
      end else if (mclr) begin
         state_q <= D_IDLE;
      end else begin
         unique case (state_q)
            D_IDLE: if (wr_go || rd_go) state_q <= D_ACT;
            D_ACT: state_q <= D_DRV;
            D_DRV: state_q <= D_CONN;
            D_CONN: if (!bus.local_execute_enable) state_q <= D_IDLE;
         endcase
      end
   end

   // direction and connect: direction first so the cpu releases the lines
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         input_q <= 1'b0;
         oe_q <= 1'b0;
         conn_q <= 1'b0;
      end else if (mclr || (state_q == D_CONN && !bus.local_execute_enable)) begin
         input_q <= 1'b0;
         oe_q <= 1'b0;
         conn_q <= 1'b0;
      end else begin
         if (rd_go) input_q <= 1'b1;
         if (state_q == D_ACT) oe_q <= input_q;
         if (state_q == D_DRV) conn_q <= 1'b1;
      end
   end

   // read data latched at decode so it is stable before connect
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dout_q <= WORD_RST;
      end else if (mclr) begin
         dout_q <= WORD_RST;
      end else if (rd_go) begin
         unique case (ri)
            RI_IN_DATA: dout_q <= ibuf_q;
            RI_IN_STAT: dout_q <= pio_status(ictl_q, iact_q, irdy_q, ierr_q);
            RI_TEST_RD: dout_q <= obuf_q;
            RI_OUT_STAT: dout_q <= pio_status(octl_q, oact_q, ordy_q, oerr_q);
            default: dout_q <= WORD_RST;
         endcase
      end
   end

   // control words; device clear bit is a one-shot and not kept
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ictl_q <= WORD_RST;
         octl_q <= WORD_RST;
      end else if (mclr) begin
         ictl_q <= WORD_RST;
         octl_q <= WORD_RST;
      end else if (wr_go && ri == RI_IN_CTL) begin
         ictl_q <= bus.io_data_lines & ~(16'h0001 << CW_CLR);
      end else if (wr_go && ri == RI_OUT_CTL) begin
         octl_q <= bus.io_data_lines & ~(16'h0001 << CW_CLR);
      end
   end

   // input side: word arrives while active, read of data clears ready
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ibuf_q <= WORD_RST;
         irdy_q <= 1'b0;
         iact_q <= 1'b0;
         ierr_q <= 4'h0;
      end else if (mclr) begin
         ibuf_q <= WORD_RST;
         irdy_q <= 1'b0;
         iact_q <= 1'b0;
         ierr_q <= 4'h0;
      end else begin
         if (wr_go && ri == RI_IN_CTL) iact_q <= bus.io_data_lines[CW_ACT];
         // an error in the clearing cycle survives so it is never lost
         if (rx_error && iact_q) begin
            ierr_q[0] <= 1'b1;
         end else if (wr_go && ri == RI_IN_CTL && bus.io_data_lines[CW_CLR]) begin
            ierr_q <= 4'h0;
         end
         // arrival beats a same-cycle clear so no word goes unseen
         if (rx_strobe && iact_q) begin
            ibuf_q <= rx_data;
            irdy_q <= 1'b1;
         end else if (wr_go && ri == RI_TEST_WR) begin
            ibuf_q <= bus.io_data_lines;
         end else if ((rd_go && ri == RI_IN_DATA) ||
                      (wr_go && ri == RI_IN_CTL && bus.io_data_lines[CW_CLR])) begin
            irdy_q <= 1'b0;
         end
      end
   end

   // output side: buffer loaded, then control with activate starts the move
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         obuf_q <= WORD_RST;
         ordy_q <= 1'b1;
         oact_q <= 1'b0;
         oerr_q <= 4'h0;
         tx_data_q <= WORD_RST;
         tx_strobe_q <= 1'b0;
      end else if (mclr) begin
         obuf_q <= WORD_RST;
         ordy_q <= 1'b1;
         oact_q <= 1'b0;
         oerr_q <= 4'h0;
         tx_data_q <= WORD_RST;
         tx_strobe_q <= 1'b0;
      end else begin
         tx_strobe_q <= 1'b0;
         if (wr_go && ri == RI_OUT_DATA) obuf_q <= bus.io_data_lines;
         if (wr_go && ri == RI_OUT_CTL && bus.io_data_lines[CW_CLR]) begin
            oerr_q <= 4'h0;
            ordy_q <= 1'b1;
            oact_q <= 1'b0;
         end else if (wr_go && ri == RI_OUT_CTL && bus.io_data_lines[CW_ACT] && !oact_q) begin
            tx_data_q <= obuf_q;
            tx_strobe_q <= 1'b1;
            ordy_q <= 1'b0;
            oact_q <= 1'b1;
         end else if (tx_done && oact_q) begin
            ordy_q <= 1'b1;
            oact_q <= 1'b0;
         end
         // error reported with done beats a same-cycle clear
         if (tx_done && oact_q && tx_error) oerr_q[0] <= 1'b1;
      end
   end

   // interrupt requests, input and output parts on their own lines
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_i_q <= 1'b0;
         irq_o_q <= 1'b0;
      end else if (mclr) begin
         irq_i_q <= 1'b0;
         irq_o_q <= 1'b0;
      end else begin
         irq_i_q <= (irdy_q && ictl_q[CW_RDY_IE]) || ((|ierr_q) && ictl_q[CW_ERR_IE]);
         irq_o_q <= (ordy_q && octl_q[CW_RDY_IE]) || ((|oerr_q) && octl_q[CW_ERR_IE]);
      end
   end

   // test flag registered so the pin comes straight from a flop
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         test_q <= 1'b0;
      end else if (mclr) begin
         test_q <= 1'b0;
      end else begin
         test_q <= octl_q[CW_TEST] | ictl_q[CW_TEST];
      end
   end

   assign bus.dev_data = dout_q;
   assign bus.dev_oe = oe_q;
   assign bus.bus_connect_ack = conn_q;
   assign bus.bus_input_direction = input_q;
   assign bus.ready_irq_in = irq_i_q;
   assign bus.ready_irq_out = irq_o_q;
   assign tx_data = tx_data_q;
   assign tx_strobe = tx_strobe_q;
   assign test_mode = test_q;
endmodule

// *** pio_cpu.sv ***
// cpu-side execute controller with branch routing, ordered over classic wishbone
// assumes a wishbone master that holds its request until ack
`timescale 1ns/1ps
module pio_cpu (
   input wire logic clk,
   input wire logic reset_n,
   pio_bus_if.cpu bus,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic dma_hold,
   input wire logic strap_local_low,
   input wire logic ext_connect,
   output logic external_execute_enable
);
   import pio_pkg::*;

   pio_cpu_state_t state_q;
   logic [AW-1:0] addr_q;
   logic [DW-1:0] acc_q;
   logic [7:0] tmo_q;
   logic ack_q, go_q, ext_q, len_q, een_q, oe_q, mclr_q, tmo_err_q, last_in_q;
   logic [31:0] dat_q;
   logic req, wr, conn, is_local;

   assign req = wb_cyc_i && wb_stb_i && !ack_q;
   // a write lands at the edge where the master sees ack, while its request still stands
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
   // strap closed: low half local, open: upper half local
   assign is_local = strap_local_low ? !addr_q[ADR_SPACE] : addr_q[ADR_SPACE];
   assign conn = ext_q ? ext_connect : bus.bus_connect_ack;

   // wishbone answer one cycle after the request; unmapped reads zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= req;
         unique case (wb_adr_i)
            WB_CMD: dat_q <= {21'h000000, addr_q};
            WB_ACC: dat_q <= {16'h0000, acc_q};
            WB_STAT: dat_q <= {26'h0000000, ext_q, bus.ready_irq_out, bus.ready_irq_in,
                               last_in_q, tmo_err_q, state_q != H_IDLE};
            default: dat_q <= 32'h0000_0000;
         endcase
      end
   end

   // command register: address write starts a cycle, ignored while busy
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         addr_q <= 11'h000;
         go_q <= 1'b0;
         mclr_q <= 1'b0;
      end else begin
         go_q <= 1'b0;
         mclr_q <= wr && wb_adr_i == WB_CMD && wb_sel_i[2] && wb_dat_i[CMD_MCLR];
         if (wr && wb_adr_i == WB_CMD && wb_sel_i[1:0] == 2'b11 && state_q == H_IDLE && !go_q) begin
            addr_q <= wb_dat_i[AW-1:0];
            go_q <= 1'b1;
         end
      end
   end

   // execute sequencer: dma first, enable until connect or timeout, then release
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= H_IDLE;
         tmo_q <= 8'h00;
         len_q <= 1'b0;
         een_q <= 1'b0;
         ext_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         unique case (state_q)
            H_IDLE: if (go_q) begin
               state_q <= H_WAIT;
               ext_q <= !is_local;
            end
            H_WAIT: if (!dma_hold) begin
               state_q <= H_EXEC;
               tmo_q <= 8'h00;
               len_q <= !ext_q;
               een_q <= ext_q;
               oe_q <= 1'b1;
            end
            H_EXEC: begin
               tmo_q <= tmo_q + 8'h01;
               oe_q <= !bus.bus_input_direction;
               if (conn || tmo_q == TIMEOUT_CNT - 8'h01) begin
                  state_q <= H_DROP;
                  len_q <= 1'b0;
                  een_q <= 1'b0;
               end
            end
            // output data kept on the lines until the card lets go of connect
            H_DROP: if (!bus.bus_connect_ack && !ext_connect) begin
               state_q <= H_IDLE;
               oe_q <= 1'b0;
            end
         endcase
      end
   end

   // accumulator: software loads it, an input cycle overwrites it at connect
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_q <= WORD_RST;
         last_in_q <= 1'b0;
      end else if (state_q == H_EXEC && conn) begin
         last_in_q <= bus.bus_input_direction;
         if (bus.bus_input_direction) acc_q <= bus.io_data_lines;
      end else if (wr && wb_adr_i == WB_ACC) begin
         if (wb_sel_i[0]) acc_q[7:0] <= wb_dat_i[7:0];
         if (wb_sel_i[1]) acc_q[15:8] <= wb_dat_i[15:8];
      end
   end

   // sticky no-connect flag, write one clears, a new timeout wins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tmo_err_q <= 1'b0;
      end else if (state_q == H_EXEC && !conn && tmo_q == TIMEOUT_CNT - 8'h01) begin
         tmo_err_q <= 1'b1;
      end else if (wr && wb_adr_i == WB_STAT && wb_sel_i[0] && wb_dat_i[1]) begin
         tmo_err_q <= 1'b0;
      end
   end

   assign bus.addr = addr_q;
   assign bus.cpu_data = acc_q;
   assign bus.cpu_oe = oe_q;
   assign bus.local_execute_enable = len_q;
   assign bus.bus_master_clear = mclr_q;
   assign external_execute_enable = een_q;
   assign wb_dat_o = dat_q;
   assign wb_ack_o = ack_q;
endmodule

// *** pio_chk.sv ***
// checker for the local i/o bus between the cpu-side controller and one card
// assumes it sees the bus interface signals of one card at the card address
`timescale 1ns/1ps
module pio_chk
   import pio_pkg::*;
#(
   parameter logic [6:0] CARD_ADDR = CARD_ADDR_RST
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] io_data_lines,
   input wire logic cpu_oe,
   input wire logic dev_oe,
   input wire logic local_execute_enable,
   input wire logic bus_connect_ack,
   input wire logic bus_input_direction,
   input wire logic bus_master_clear,
   input wire logic ready_irq_in,
   input wire logic ready_irq_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // card compares only the upper register-address bits
   wire match = addr[9:3] == CARD_ADDR;

   chk_conn_after_en: assert property ($rose(bus_connect_ack) |-> local_execute_enable && match)
      else $error("connect raised without own enable");
   chk_conn_in_time: assert property ($rose(local_execute_enable) && match |-> ##[1:5] bus_connect_ack)
      else $error("connect late");
   chk_conn_hold: assert property (bus_connect_ack && local_execute_enable |=> bus_connect_ack)
      else $error("connect dropped early");
   chk_conn_release: assert property ($fell(local_execute_enable) |=> !bus_connect_ack && !bus_input_direction)
      else $error("connect or direction kept");
   chk_in_drives: assert property (bus_connect_ack && bus_input_direction |-> dev_oe && !cpu_oe)
      else $error("input cycle bus driver wrong");
   chk_out_drives: assert property (bus_connect_ack && !bus_input_direction |-> cpu_oe && !dev_oe)
      else $error("output cycle bus driver wrong");
   chk_dir_addr: assert property (bus_connect_ack |-> bus_input_direction == !addr[ADR_DIR])
      else $error("direction disagrees with address");
   chk_in_stable: assert property (bus_connect_ack && bus_input_direction ##1 bus_connect_ack |-> $stable(io_data_lines))
      else $error("input data moved under connect");
   chk_foreign_quiet: assert property (local_execute_enable && !match |-> !bus_connect_ack)
      else $error("connect for foreign address");
   chk_clear_all: assert property (bus_master_clear |-> ##2 !ready_irq_in && !ready_irq_out)
      else $error("interrupts survive master clear");

   cover property (bus_connect_ack && bus_input_direction);
   cover property (bus_connect_ack && !bus_input_direction);
   cover property (bus_master_clear);
endmodule

// *** programmed_io_interface_tb.sv ***
// self-checking bench: cpu controller and card joined by the bus interface
// assumes wishbone ack one cycle after a request and a 250 cycle no-connect limit
`timescale 1ns/1ps
module programmed_io_interface_tb;
   import pio_pkg::*;
   logic clk = 0, reset_n = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack_o;
   logic [7:0] wb_adr = 0;
   logic [31:0] wb_dat = 0, wb_dat_o, q;
   logic [15:0] rx_data = 0, tx_data, r, tx_seen;
   logic rx_strobe = 0, rx_error = 0, tx_strobe, tx_done = 0, tx_error = 0, test_mode, dma_hold = 0;
   logic strap_local_low = 1, ext_connect = 0, external_execute_enable, ext_seen = 0, en_seen = 0;
   int mismatches = 0, checks_done = 0, cycles = 0;

   pio_bus_if i_pio_bus_if();
   pio_card i_pio_card(.clk(clk), .reset_n(reset_n), .bus(i_pio_bus_if), .rx_data(rx_data), .rx_strobe(rx_strobe),
      .rx_error(rx_error), .tx_data(tx_data), .tx_strobe(tx_strobe), .tx_done(tx_done), .tx_error(tx_error),
      .test_mode(test_mode));
   pio_cpu i_pio_cpu(.clk(clk), .reset_n(reset_n), .bus(i_pio_bus_if), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .dma_hold(dma_hold), .strap_local_low(strap_local_low), .ext_connect(ext_connect),
      .external_execute_enable(external_execute_enable));
   pio_chk #(.CARD_ADDR(CARD_ADDR_RST)) i_pio_chk(.clk(clk), .reset_n(reset_n), .addr(i_pio_bus_if.addr),
      .io_data_lines(i_pio_bus_if.io_data_lines), .cpu_oe(i_pio_bus_if.cpu_oe), .dev_oe(i_pio_bus_if.dev_oe),
      .local_execute_enable(i_pio_bus_if.local_execute_enable), .bus_connect_ack(i_pio_bus_if.bus_connect_ack),
      .bus_input_direction(i_pio_bus_if.bus_input_direction), .bus_master_clear(i_pio_bus_if.bus_master_clear),
      .ready_irq_in(i_pio_bus_if.ready_irq_in), .ready_irq_out(i_pio_bus_if.ready_irq_out));

   initial forever #10 clk = ~clk;

   // watchers and a one-cycle external responder; the ceiling cuts a hang short
   always @(posedge clk) begin
      cycles++;
      ext_connect <= external_execute_enable;
      if (tx_strobe) tx_seen <= tx_data;
      if (external_execute_enable) ext_seen <= 1;
      if (i_pio_bus_if.local_execute_enable) en_seen <= 1;
      if (cycles > 40000) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, cycles, 40000);
         wrap_up;
      end
   end

   task cmp(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // classic single cycle, held until the edge that samples ack
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      wb_cyc <= 1; wb_stb <= 1; wb_we <= w; wb_adr <= a; wb_dat <= d;
      // no count of its own: only the bench ceiling ends a wait
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc <= 0; wb_stb <= 0; wb_we <= 0;
      @(posedge clk);
   endtask

   task idle;
      do wb(0, WB_STAT, 0); while (q[0] !== 1'b0);
   endtask

   // one execute cycle: load accumulator, start, wait, read accumulator back
   task io_execute_instruction(input logic [10:0] a, input logic [15:0] w);
      wb(1, WB_ACC, 32'(w));
      wb(1, WB_CMD, 32'(a));
      idle;
      wb(0, WB_ACC, 0);
      r = q[15:0];
   endtask

   function automatic logic [10:0] ca(input logic [2:0] ri);
      return {1'b0, CARD_ADDR_RST, ri};
   endfunction

   task t_output;
      io_execute_instruction(ca(RI_OUT_STAT), 0); cmp(r, 16'h0008);
      io_execute_instruction(ca(RI_OUT_DATA), 16'h5a3c); cmp(r, 16'h5a3c);
      io_execute_instruction(ca(RI_TEST_RD), 0); cmp(r, 16'h5a3c);
      io_execute_instruction(ca(RI_OUT_CTL), 16'h0005); cmp(tx_seen, 16'h5a3c);
      io_execute_instruction(ca(RI_OUT_STAT), 0); cmp(r, 16'h0005);
      cmp(16'(i_pio_bus_if.ready_irq_out), 0);
      tx_done <= 1; tx_error <= 1; @(posedge clk); tx_done <= 0; tx_error <= 0; repeat (2) @(posedge clk);
      cmp(16'(i_pio_bus_if.ready_irq_out), 1);
      io_execute_instruction(ca(RI_OUT_STAT), 0); cmp(r & 16'h000b, 16'h0009);
      cmp(r & 16'h01f0, 16'h0030);
   endtask

   task t_input;
      io_execute_instruction(ca(RI_IN_STAT), 0); cmp(r, 16'h0000);
      io_execute_instruction(ca(RI_IN_CTL), 16'h0007);
      rx_data <= 16'hc3a1; rx_strobe <= 1; @(posedge clk); rx_strobe <= 0; repeat (2) @(posedge clk);
      cmp(16'(i_pio_bus_if.ready_irq_in), 1);
      io_execute_instruction(ca(RI_IN_STAT), 0); cmp(r, 16'h000f);
      io_execute_instruction(ca(RI_IN_DATA), 16'h1111); cmp(r, 16'hc3a1);
      wb(0, WB_STAT, 0); cmp(16'(q[2]), 1);
      io_execute_instruction(ca(RI_IN_STAT), 0); cmp(r, 16'h0007);
      rx_error <= 1; @(posedge clk); rx_error <= 0;
      io_execute_instruction(ca(RI_IN_STAT), 0); cmp(r & 16'h01f0, 16'h0030);
      io_execute_instruction(ca(RI_IN_CTL), 16'h0017);
      io_execute_instruction(ca(RI_IN_STAT), 0); cmp(r, 16'h0007);
      io_execute_instruction(ca(RI_TEST_WR), 16'h9b64); io_execute_instruction(ca(RI_IN_DATA), 0); cmp(r, 16'h9b64);
   endtask

   // foreign address: no connect, timeout flag, accumulator kept
   task t_nomatch;
      io_execute_instruction({1'b0, 7'h11, 3'h0}, 16'h7e81); cmp(r, 16'h7e81);
      wb(0, WB_STAT, 0); cmp(16'(q[1]), 1);
      wb(1, WB_STAT, 32'h2); wb(0, WB_STAT, 0); cmp(16'(q[1]), 0);
   endtask

   task t_dma;
      dma_hold <= 1; en_seen <= 0;
      wb(1, WB_CMD, 32'(ca(RI_OUT_STAT)));
      repeat (20) @(posedge clk);
      cmp(16'(en_seen), 0);
      wb(0, WB_STAT, 0); cmp(16'(q[0]), 1);
      dma_hold <= 0;
      idle;
      cmp(16'(en_seen), 1);
   endtask

   // strap picks which space bit stays local
   task t_route;
      for (int s = 0; s < 2; s++) begin
         strap_local_low <= s[0]; ext_seen <= 0; en_seen <= 0;
         io_execute_instruction({1'b1, CARD_ADDR_RST, RI_OUT_STAT}, 0);
         cmp(16'(ext_seen), 16'(s == 1));
         cmp(16'(en_seen), 16'(s == 0));
         wb(0, WB_STAT, 0); cmp(16'(q[5]), 16'(s == 1));
      end
      strap_local_low <= 1;
   endtask

   task t_clear;
      io_execute_instruction(ca(RI_OUT_CTL), 16'h0008); cmp(16'(test_mode), 1);
      wb(1, WB_CMD, 32'h10000); repeat (3) @(posedge clk);
      cmp(16'(test_mode), 0);
      idle;
      io_execute_instruction(ca(RI_OUT_STAT), 0); cmp(r, 16'h0008);
      io_execute_instruction(ca(RI_IN_STAT), 0); cmp(r, 16'h0000);
   endtask

   task wrap_up;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1;
      @(posedge clk);
      t_output;
      t_input;
      t_nomatch;
      t_dma;
      t_route;
      t_clear;
      wrap_up;
   end
endmodule
